//--- rtl/line_driver_config_cmd.sv
// configuration command interpreter, parameter store and edge control
// assumes command bytes arrive from an external receiver as pulses
// Operation
// - upper rate codes invert receive polarity
// - response goes out at new rate
// - rate codes map to four rates twice
// - program pulse codes map, 111 unlimited
// - strong pullup codes map, 111 unlimited
// - slew codes map to nominal rates
// - load is 1.8 mA plus 0.3 steps
// - write command layout 0,par,val,1
// - read command layout 0000,par,1
// - response bit 0 zero, write echoes
// - read response returns stored value code
// - rising boost always, slew only flexible
// - weak pullup first, strong past threshold
// - timer holds strong pullup then weak
// - weak pullup off before pulling low
// - reset loads default value codes
// - standard waveforms unless flexible and changed
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "line_driver_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module line_driver_config_cmd
  import line_driver_pkg::*;
#(
  parameter int DIV_W      = 12,
  parameter int HOLD_CYC   = `BOOST_HOLD_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // command bytes and responses
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  output logic             cmd_ready,
  output logic             resp_valid,
  output logic      [7:0]  resp_byte,
  output logic             txd,
  // receive polarity and serial rate divisor
  input  wire logic        polarity_select_pin,
  output logic             rx_invert,
  output logic [DIV_W-1:0] baud_div,
  // decoded parameter values
  output logic      [11:0] program_pulse_us,
  output logic      [13:0] strong_pullup_tenth_ms,
  output logic      [3:0]  write_one_low_us,
  output logic      [3:0]  sample_offset_us,
  output logic      [13:0] slew_mv_per_us,
  output logic      [5:0]  load_tenth_ma,
  // edge shaping
  input  wire logic        drive_low_req,
  input  wire logic        above_boost_thr,
  input  wire logic        above_timer_thr,
  output logic             weak_pullup_en,
  output logic             strong_pullup_en,
  output logic             pulldown_en,
  output logic             slew_ctrl_en,
  output logic      [2:0]  slew_code
);

  // ***********************************
  // storage
  // ***********************************
  value_code_t param_q [1:7];
  logic        flex_q;
  logic        send_q;
  logic [7:0]  resp_q;
  logic [31:0] rdata_q;
  edge_state_t st_q;
  edge_state_t st_d;
  logic [15:0] hold_q;

  // ***********************************
  // command decode
  // ***********************************
  wire         tx_busy;
  wire         tx_line;
  wire         frame_ok;
  wire         is_read;
  wire         is_write;
  wire         take;
  wire [2:0]   cmd_par;
  wire [2:0]   cmd_val;
  wire [2:0]   rd_par;
  wire [2:0]   rd_val;
  wire [7:0]   resp_d;

  assign frame_ok = !cmd_byte[`CMD_TOP_BIT] && cmd_byte[`CMD_ONE_BIT];
  assign cmd_par  = cmd_byte[`CMD_PAR_HI:`CMD_PAR_LO];
  assign cmd_val  = cmd_byte[`CMD_VAL_HI:`CMD_VAL_LO];
  assign is_read  = frame_ok && (cmd_par == 3'h0);
  assign is_write = frame_ok && (cmd_par != 3'h0);
  assign cmd_ready = !tx_busy && !send_q;
  assign take     = cmd_valid && cmd_ready && frame_ok;
  assign rd_par   = cmd_val;
  assign rd_val   = (rd_par == 3'h0) ? 3'h0 : param_q[rd_par];
  assign resp_d   = is_read ? {cmd_byte[7:4], rd_val, 1'b0}
                            : {cmd_byte[7:1], 1'b0};

  // ***********************************
  // parameter store
  // ***********************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      param_q[`PAR_SLEW] <= `RST_SLEW;
      param_q[`PAR_PROG] <= `RST_PROG;
      param_q[`PAR_SPU]  <= `RST_SPU;
      param_q[`PAR_W1L]  <= `RST_W1L;
      param_q[`PAR_DSO]  <= `RST_DSO;
      param_q[`PAR_LOAD] <= `RST_LOAD;
      param_q[`PAR_RATE] <= `RST_RATE;
    end else if (take && is_write) begin
      param_q[cmd_par] <= cmd_val;
    end
  end

  // ***********************************
  // response launch
  // ***********************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      send_q <= 1'b0;
      resp_q <= 8'h00;
    end else begin
      send_q <= take;
      if (take) begin
        resp_q <= resp_d;
      end
    end
  end

  assign resp_valid = send_q;
  assign resp_byte  = resp_q;

  // ***********************************
  // serial rate and polarity
  // ***********************************
  wire [2:0] rate_c;

  assign rate_c    = param_q[`PAR_RATE];
  assign baud_div  = (rate_c[1:0] == 2'h0) ? DIV_W'(`DIV_0) :
                     (rate_c[1:0] == 2'h1) ? DIV_W'(`DIV_1) :
                     (rate_c[1:0] == 2'h2) ? DIV_W'(`DIV_2) :
                                             DIV_W'(`DIV_3);
  assign rx_invert = polarity_select_pin ^ rate_c[2];

  // divisor already updated when send_q fires
  serial_resp_tx #(
    .DIV_W (DIV_W)
  ) u_tx (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .start   (send_q),
    .data    (resp_q),
    .div     (baud_div),
    .line    (tx_line),
    .busy    (tx_busy)
  );

  assign txd = tx_line;

  // ***********************************
  // decoded values
  // ***********************************
  wire [2:0] prog_c;
  wire [2:0] spu_c;
  wire [2:0] slew_c;
  wire       slew_changed;
  wire       flex_active;

  assign prog_c = param_q[`PAR_PROG];
  assign spu_c  = param_q[`PAR_SPU];
  assign slew_c = param_q[`PAR_SLEW];

  // zero means unlimited
  assign program_pulse_us = (prog_c == 3'h7) ? 12'h000
                          : (12'h020 << prog_c);

  // code 110 is not to be written by the host
  assign strong_pullup_tenth_ms =
      (spu_c == 3'h0) ? 14'h00a4 :
      (spu_c == 3'h1) ? 14'h028f :
      (spu_c == 3'h2) ? 14'h051e :
      (spu_c == 3'h3) ? 14'h0a3c :
      (spu_c == 3'h4) ? 14'h1478 :
      (spu_c == 3'h5) ? 14'h28f0 :
                        14'h0000;

  assign slew_changed = (slew_c != `RST_SLEW);
  assign flex_active  = flex_q && ((param_q[`PAR_W1L] != `RST_W1L) ||
                                   (param_q[`PAR_DSO] != `RST_DSO) ||
                                   slew_changed);

  // standard timing unless flexible speed with a changed value
  assign write_one_low_us = flex_active ? (4'h8 + {1'b0, param_q[`PAR_W1L]})
                                        : 4'h8;
  assign sample_offset_us = flex_active ? (4'h3 + {1'b0, param_q[`PAR_DSO]})
                                        : 4'h3;

  assign slew_code    = slew_ctrl_en ? slew_c : `RST_SLEW;
  assign slew_ctrl_en = flex_q && slew_changed;
  assign slew_mv_per_us =
      (slew_code == 3'h0) ? 14'h3a98 :
      (slew_code == 3'h1) ? 14'h0898 :
      (slew_code == 3'h2) ? 14'h0672 :
      (slew_code == 3'h3) ? 14'h055a :
      (slew_code == 3'h4) ? 14'h044c :
      (slew_code == 3'h5) ? 14'h033e :
      (slew_code == 3'h6) ? 14'h02bc :
                            14'h0226;

  assign load_tenth_ma = 6'h12 + 6'(3 * param_q[`PAR_LOAD]);

  // ***********************************
  // edge shaping
  // ***********************************
  wire hold_done;

  assign hold_done = (hold_q == 16'(HOLD_CYC - 1));

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      EDGE_IDLE: begin
        if (drive_low_req) begin
          st_d = EDGE_PREP;
        end else if (!above_boost_thr) begin
          st_d = EDGE_RISE;
        end
      end
      EDGE_PREP: begin
        st_d = EDGE_LOW;
      end
      EDGE_LOW: begin
        if (!drive_low_req) begin
          st_d = EDGE_RISE;
        end
      end
      EDGE_RISE: begin
        if (drive_low_req) begin
          st_d = EDGE_PREP;
        end else if (above_boost_thr) begin
          st_d = EDGE_BOOST;
        end
      end
      EDGE_BOOST: begin
        if (drive_low_req) begin
          st_d = EDGE_PREP;
        end else if (above_timer_thr) begin
          st_d = EDGE_HOLD;
        end
      end
      EDGE_HOLD: begin
        if (drive_low_req) begin
          st_d = EDGE_PREP;
        end else if (hold_done) begin
          st_d = EDGE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= EDGE_IDLE;
      hold_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      if (st_q == EDGE_HOLD) begin
        hold_q <= hold_q + 16'h0001;
      end else begin
        hold_q <= 16'h0000;
      end
    end
  end

  // boost path is active at every speed
  assign weak_pullup_en   = (st_q == EDGE_IDLE) || (st_q == EDGE_RISE);
  assign strong_pullup_en = (st_q == EDGE_BOOST) || (st_q == EDGE_HOLD);
  assign pulldown_en      = (st_q == EDGE_LOW);

  // ***********************************
  // register port
  // ***********************************
  wire        wr_ctrl;
  wire [31:0] rd_mux;

  assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL_OFS);
  assign rd_mux  =
      (reg_addr == `REG_CTRL_OFS)  ? {31'h0, flex_q} :
      (reg_addr == `REG_CODES_OFS) ? {11'h0, param_q[7], param_q[6],
                                      param_q[5], param_q[4], param_q[3],
                                      param_q[2], param_q[1]} :
      (reg_addr == `REG_RESP_OFS)  ? {22'h0, tx_busy, send_q, resp_q} :
      (reg_addr == `REG_EDGE_OFS)  ? {26'h0, slew_ctrl_en, flex_active,
                                      pulldown_en, strong_pullup_en,
                                      weak_pullup_en, rx_invert} :
                                     32'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flex_q  <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        flex_q <= reg_wdata[`CTRL_FLEX_BIT];
      end
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // line_driver_config_cmd

`default_nettype wire

//--- pkg/line_driver_consts.svh
// constants for the line driver configuration block
// assumes a 25 MHz system clock
`ifndef LINE_DRIVER_CONSTS_SVH
`define LINE_DRIVER_CONSTS_SVH

// ***********************************
// register offsets (byte addresses)
// ***********************************
`define REG_CTRL_OFS     4'h0
`define REG_CODES_OFS    4'h4
`define REG_RESP_OFS     4'h8
`define REG_EDGE_OFS     4'hc
`define CTRL_FLEX_BIT    0

// ***********************************
// command byte fields
// ***********************************
`define CMD_TOP_BIT      7
`define CMD_PAR_HI       6
`define CMD_PAR_LO       4
`define CMD_VAL_HI       3
`define CMD_VAL_LO       1
`define CMD_ONE_BIT      0

// ***********************************
// parameter codes
// ***********************************
`define PAR_SLEW         3'h1
`define PAR_PROG         3'h2
`define PAR_SPU          3'h3
`define PAR_W1L          3'h4
`define PAR_DSO          3'h5
`define PAR_LOAD         3'h6
`define PAR_RATE         3'h7

// ***********************************
// reset value codes
// ***********************************
`define RST_SLEW         3'h0
`define RST_PROG         3'h4
`define RST_SPU          3'h4
`define RST_W1L          3'h0
`define RST_DSO          3'h0
`define RST_LOAD         3'h0
`define RST_RATE         3'h0

// ***********************************
// timing
// ***********************************
`define CLK_HZ           25000000
`define RATE_0_BPS       9600
`define RATE_1_BPS       19200
`define RATE_2_BPS       57600
`define RATE_3_BPS       115200
`define DIV_0            (`CLK_HZ / `RATE_0_BPS)
`define DIV_1            (`CLK_HZ / `RATE_1_BPS)
`define DIV_2            (`CLK_HZ / `RATE_2_BPS)
`define DIV_3            (`CLK_HZ / `RATE_3_BPS)
`define BOOST_HOLD_NS    2000
`define CLK_NS           40
`define BOOST_HOLD_CYC   (`BOOST_HOLD_NS / `CLK_NS)

`endif

//--- pkg/line_driver_pkg.sv
// types for the line driver configuration block
// assumes the constants header alongside
package line_driver_pkg;

  typedef enum logic [2:0] {
    EDGE_IDLE,
    EDGE_PREP,
    EDGE_LOW,
    EDGE_RISE,
    EDGE_BOOST,
    EDGE_HOLD
  } edge_state_t;

  typedef logic [2:0] value_code_t;

endpackage

//--- rtl/serial_resp_tx.sv
// serial transmitter for response bytes
// assumes divisor held steady while a byte is sent
`timescale 1ns/1ps
`default_nettype none

module serial_resp_tx #(
  parameter int DIV_W = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             start,
  input  wire logic [7:0]       data,
  input  wire logic [DIV_W-1:0] div,
  output logic                  line,
  output logic                  busy
);

  logic [DIV_W-1:0] cnt_q;
  logic [9:0]       shf_q;
  logic [3:0]       bits_q;
  logic             tick;

  // ***********************************
  // bit timing
  // ***********************************
  assign tick = (cnt_q == div - {{(DIV_W-1){1'b0}}, 1'b1});
  assign line = busy ? shf_q[0] : 1'b1;
  assign busy = (bits_q != 4'h0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= '0;
      shf_q  <= 10'h3ff;
      bits_q <= 4'h0;
    end else if (start && !busy) begin
      cnt_q  <= '0;
      shf_q  <= {1'b1, data, 1'b0};
      bits_q <= 4'ha;
    end else if (busy) begin
      if (tick) begin
        cnt_q  <= '0;
        shf_q  <= {1'b1, shf_q[9:1]};
        bits_q <= bits_q - 4'h1;
      end else begin
        cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // serial_resp_tx

`default_nettype wire

//--- tb/line_driver_config_cmd_props.sv
// assertions on the command block ports
// assumes binding into line_driver_config_cmd
`include "line_driver_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module line_driver_config_cmd_props #(
  parameter int DIV_W = 12
) (
  input wire logic             clk_sys,
  input wire logic             arst_n,
  input wire logic             cmd_valid,
  input wire logic [7:0]       cmd_byte,
  input wire logic             cmd_ready,
  input wire logic             resp_valid,
  input wire logic [7:0]       resp_byte,
  input wire logic             txd,
  input wire logic             polarity_select_pin,
  input wire logic             rx_invert,
  input wire logic [DIV_W-1:0] baud_div,
  input wire logic [11:0]      program_pulse_us,
  input wire logic [5:0]       load_tenth_ma,
  input wire logic             weak_pullup_en,
  input wire logic             pulldown_en,
  input wire logic             slew_ctrl_en,
  input wire logic [2:0]       slew_code
);
  // ****************
  // checks
  // ****************
  localparam int DV [4] = '{`DIV_0, `DIV_1, `DIV_2, `DIV_3};
  wire acc = cmd_valid && cmd_ready && !cmd_byte[7] && cmd_byte[0];
  wire [2:0] par = cmd_byte[6:4];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_rx_polarity: assert property (
    acc && par == 3'h7 |=> rx_invert == (polarity_select_pin ^ $past(cmd_byte[3])))
    else $error("rx polarity wrong");
  chk_rate_div: assert property (
    acc && par == 3'h7 |=> baud_div == DV[$past(cmd_byte[2:1])])
    else $error("rate divisor wrong");
  chk_write_echo: assert property (
    acc && par != 3'h0 |=> resp_valid && resp_byte == {$past(cmd_byte[7:1]), 1'h0})
    else $error("write echo wrong");
  chk_resp_bit_zero: assert property (
    resp_valid |-> !resp_byte[0] && !cmd_ready)
    else $error("response bit0 or ready wrong");
  chk_tx_start: assert property (
    resp_valid |=> !txd [*8])
    else $error("start bit missing");
  chk_prog_map: assert property (
    acc && par == 3'h2 |=> program_pulse_us ==
      ($past(cmd_byte[3:1]) == 3'h7 ? 12'h0 : 12'h20 << $past(cmd_byte[3:1])))
    else $error("program pulse map wrong");
  chk_load_map: assert property (
    acc && par == 3'h6 |=> load_tenth_ma == 6'h12 + 6'h3 * $past(cmd_byte[3:1]))
    else $error("load map wrong");
  chk_weak_first: assert property (
    $rose(pulldown_en) |-> !$past(weak_pullup_en) && !weak_pullup_en)
    else $error("weak pullup on at pulldown");
  chk_slew_gate: assert property (
    slew_ctrl_en == (slew_code != 3'h0))
    else $error("slew gate wrong");
  chk_no_spurious: assert property (
    !acc |=> !resp_valid)
    else $error("response without command");
endmodule // line_driver_config_cmd_props

bind line_driver_config_cmd line_driver_config_cmd_props #(.DIV_W(DIV_W)) props_inst (
  .clk_sys, .arst_n, .cmd_valid, .cmd_byte, .cmd_ready, .resp_valid, .resp_byte, .txd,
  .polarity_select_pin, .rx_invert, .baud_div, .program_pulse_us, .load_tenth_ma,
  .weak_pullup_en, .pulldown_en, .slew_ctrl_en, .slew_code);
`default_nettype wire

//--- tb/host_uart_model.sv
// host serial receiver for response bytes
// assumes 8N1, lsb first, divisor from the host's own rate
`timescale 1ns/1ps
`default_nettype none

module host_uart_model (
  input  wire logic        clk_sys,
  input  wire logic        txd,
  input  wire logic [11:0] div,
  output logic      [7:0]  rx_byte,
  output logic             rx_ok,
  output logic             rx_done
);
  // ****************
  // receiver
  // ****************
  initial begin
    rx_byte = 8'h0;
    rx_ok = 1'h0;
    rx_done = 1'h0;
    forever begin
      @(negedge txd);
      repeat (div / 2) @(posedge clk_sys);
      rx_ok = !txd;
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk_sys);
        rx_byte[i] = txd;
      end
      repeat (div) @(posedge clk_sys);
      rx_ok = rx_ok && txd;
      rx_done = 1'h1;
      @(posedge clk_sys);
      rx_done = 1'h0;
    end
  end
endmodule // host_uart_model
`default_nettype wire

//--- tb/line_driver_config_cmd_test.sv
// self-checking bench for the command block
// assumes host_uart_model and the bound checker
`include "line_driver_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module line_driver_config_cmd_test;
  // ****************
  // signals
  // ****************
  logic        clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0;
  logic        polarity_select_pin = 0, drive_low_req = 0, flex = 0;
  logic        above_boost_thr = 1, above_timer_thr = 1;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic [7:0]  cmd_byte = 0;
  logic [2:0]  mem [8];
  logic [2:0]  v;
  wire  [31:0] reg_rdata;
  wire  [11:0] baud_div, program_pulse_us;
  wire  [13:0] strong_pullup_tenth_ms, slew_mv_per_us;
  wire  [7:0]  resp_byte, rx_byte;
  wire  [5:0]  load_tenth_ma;
  wire  [3:0]  write_one_low_us, sample_offset_us;
  wire  [2:0]  slew_code;
  wire         cmd_ready, resp_valid, txd, rx_invert, weak_pullup_en, strong_pullup_en;
  wire         pulldown_en, slew_ctrl_en, rx_ok, rx_done;
  int          fails = 0, n_tests = 0, cyc = 0, k;
  integer      seed = 32'h49998608;
  localparam int HOLD = 4;
  localparam int DV [4] = '{`DIV_0, `DIV_1, `DIV_2, `DIV_3};
  localparam logic [2:0] RATES [6] = '{3'h3, 3'h7, 3'h2, 3'h6, 3'h1, 3'h3};
  localparam logic [13:0] SPU [8] = '{14'ha4, 14'h28f, 14'h51e, 14'ha3c, 14'h1478,
                                      14'h28f0, 14'h0, 14'h0};
  localparam logic [13:0] SLW [8] = '{14'h3a98, 14'h898, 14'h672, 14'h55a, 14'h44c,
                                      14'h33e, 14'h2bc, 14'h226};
  wire  [11:0] hdiv = 12'(DV[mem[7][1:0]]);

  line_driver_config_cmd #(.HOLD_CYC(HOLD)) line_driver_config_cmd_inst (
    .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmd_valid, .cmd_byte, .cmd_ready, .resp_valid, .resp_byte, .txd,
    .polarity_select_pin, .rx_invert, .baud_div, .program_pulse_us,
    .strong_pullup_tenth_ms, .write_one_low_us, .sample_offset_us, .slew_mv_per_us,
    .load_tenth_ma, .drive_low_req, .above_boost_thr, .above_timer_thr,
    .weak_pullup_en, .strong_pullup_en, .pulldown_en, .slew_ctrl_en, .slew_code);
  host_uart_model host_uart_model_inst (
    .clk_sys, .txd, .div(hdiv), .rx_byte, .rx_ok, .rx_done);

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      complete_run();
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic complete_run();
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic init_mem();
    foreach (mem[i]) mem[i] = 3'h0;
    mem[2] = 3'h4;
    mem[3] = 3'h4;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic wait_ready();
    k = 0;
    while (cmd_ready !== 1'h1 && k < 30000) begin
      @(posedge clk_sys);
      #1 k++;
    end
  endtask
  task automatic refuse(input logic [7:0] b);
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_byte <= b;
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    #1 `CHK(resp_valid, 1'h0)
  endtask
  task automatic send(input logic [7:0] b);
    logic [7:0] e;
    wait_ready();
    e = (b[7:4] == 4'h0) ? {b[7:4], mem[b[3:1]], 1'h0} : {b[7:1], 1'h0};
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_byte <= b;
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    if (b[7:4] != 4'h0) mem[b[6:4]] = b[3:1];
    #1 `CHK(resp_valid, 1'h1)
    `CHK(resp_byte, e)
    k = 0;
    while (rx_done !== 1'h1 && k < 30000) begin
      @(posedge clk_sys);
      #1 k++;
    end
    `CHK({rx_ok, rx_byte}, {1'h1, e})
  endtask
  task automatic check_dec();
    logic fa;
    fa = flex && (mem[1] | mem[4] | mem[5]) != 3'h0;
    `CHK(program_pulse_us, mem[2] == 3'h7 ? 12'h0 : 12'h20 << mem[2])
    `CHK(strong_pullup_tenth_ms, SPU[mem[3]])
    `CHK(write_one_low_us, fa ? 4'h8 + mem[4] : 4'h8)
    `CHK(sample_offset_us, fa ? 4'h3 + mem[5] : 4'h3)
    `CHK(load_tenth_ma, 6'h12 + 6'h3 * mem[6])
    `CHK(slew_ctrl_en, flex && mem[1] != 3'h0)
    `CHK(slew_mv_per_us, SLW[flex ? mem[1] : 3'h0])
    `CHK(baud_div, hdiv)
    `CHK(rx_invert, polarity_select_pin ^ mem[7][2])
  endtask

  // ****************
  // sequence
  // ****************
  initial begin
    init_mem();
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'h1;
    rd(4'h4, 32'h120);
    check_dec();
    wr(4'h4, 32'hffffffff);
    rd(4'h4, 32'h120);
    rd(4'h2, 32'h0);
    foreach (RATES[i]) begin
      @(posedge clk_sys);
      polarity_select_pin <= i[0];
      send({4'h7, RATES[i], 1'h1});
      check_dec();
    end
    for (int f = 0; f < 2; f++) begin
      wr(4'h0, {31'h0, f[0]});
      flex = f[0];
      rd(4'h0, {31'h0, f[0]});
      for (int p = 1; p < 7; p++) begin
        v = 3'($random(seed));
        if (p == 3 && v == 3'h6) v = 3'h5;
        send({1'h0, 3'(p), v, 1'h1});
        check_dec();
        if (f == 1) send({4'h0, 3'(p), 1'h1});
      end
    end
    send(8'h19);
    refuse(8'h1b);
    wait_ready();
    refuse(8'h9b);
    refuse(8'h1a);
    send(8'h03);
    send(8'h01);
    check_dec();
    @(posedge clk_sys);
    drive_low_req <= 1'h1;
    @(posedge clk_sys);
    #1 `CHK({weak_pullup_en, pulldown_en}, 2'h0)
    @(posedge clk_sys);
    #1 `CHK(pulldown_en, 1'h1)
    @(posedge clk_sys);
    drive_low_req <= 1'h0;
    above_boost_thr <= 1'h0;
    above_timer_thr <= 1'h0;
    @(posedge clk_sys);
    #1 `CHK({weak_pullup_en, strong_pullup_en}, 2'h2)
    @(posedge clk_sys);
    above_boost_thr <= 1'h1;
    @(posedge clk_sys);
    #1 `CHK({weak_pullup_en, strong_pullup_en}, 2'h1)
    @(posedge clk_sys);
    above_timer_thr <= 1'h1;
    k = 0;
    repeat (12) begin
      @(posedge clk_sys);
      #1 if (strong_pullup_en === 1'h1) k++;
    end
    `CHK(k, HOLD)
    `CHK(weak_pullup_en, 1'h1)
    @(posedge clk_sys);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'h1;
    init_mem();
    flex = 1'h0;
    rd(4'h4, 32'h120);
    send(8'h77);
    send(8'h19);
    check_dec();
    rd(4'h8, 32'h218);
    rd(4'hc, 32'h3);
    complete_run();
  end
endmodule // line_driver_config_cmd_test
`default_nettype wire
